// [rtl/kms_pkg.sv]
// Constants and types shared by the keypad matrix scanner
package kms_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] ADDR_DIR = 8'h00;
  localparam logic [7:0] ADDR_LVL = 8'h04;
  localparam logic [7:0] ADDR_RET = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_SIN = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;

  // Reset values
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] LVL_RST = 8'hff;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Field positions
  localparam int CTRL_SCAN_EN_BIT = 0;
  localparam int CTRL_INT_TICK_BIT = 1;
  localparam int STAT_KEY_BIT = 0;
  localparam int STAT_POS_LSB = 8;

  // Geometry
  localparam int NUM_STROBES = 8;
  localparam int NUM_RETURNS = 5;

  // Frame timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int FRAME_NS = 4600000;
  localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;
  localparam int FRAME_CNT_W = 18;

  // Scan position, one-hot: the set bit is the strobe driven low
  typedef enum logic [7:0] {
    SCAN_S0 = 8'h01,
    SCAN_S1 = 8'h02,
    SCAN_S2 = 8'h04,
    SCAN_S3 = 8'h08,
    SCAN_S4 = 8'h10,
    SCAN_S5 = 8'h20,
    SCAN_S6 = 8'h40,
    SCAN_S7 = 8'h80
  } kms_scan_t;

endpackage : kms_pkg

// [rtl/kms_frame_timer.sv]
// Frame tick divider for the keypad matrix scanner
`timescale 1ns/1ps
`default_nettype none

module kms_frame_timer #(
  parameter int FRAME_CYCLES = kms_pkg::FRAME_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and tick
  input wire logic enable,
  output logic tick
);

  typedef struct packed {
    logic [kms_pkg::FRAME_CNT_W-1:0] cnt;
    logic tick;
  } kms_timer_t;

  kms_timer_t st_q;
  kms_timer_t st_d;

  localparam logic [kms_pkg::FRAME_CNT_W-1:0] LAST =
    kms_pkg::FRAME_CNT_W'(FRAME_CYCLES - 1);

  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    // Stopped timer restarts a full frame when enabled again
    if (!enable)
    begin
      st_d.cnt = '0;
    end
    else if (st_q.cnt == LAST)
    begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule : kms_frame_timer

`default_nettype wire

// [rtl/kms_scanner.sv]
// Keypad matrix scanner with APB register access
`timescale 1ns/1ps
`default_nettype none

module kms_scanner #(
  parameter int FRAME_CYCLES = kms_pkg::FRAME_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strobe pins
  input wire logic [7:0] strobe_i,
  output logic [7:0] strobe_o,
  output logic [7:0] strobe_oe,
  // Return pins and shared port A bit 0
  input wire logic [3:0] ret_i,
  input wire logic gpa0_i,
  input wire logic gpa0_alt_sel,
  // Frame timing and interrupt
  input wire logic frame_tick,
  output logic key_irq
);

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] lvl;
    logic [7:0] mask;
    logic [1:0] ctrl;
    logic key_seen;
    kms_pkg::kms_scan_t pos;
    logic [7:0] sin_m;
    logic [7:0] sin;
    logic [4:0] ret_m;
    logic [4:0] ret;
    logic [7:0] strobe_o;
    logic [7:0] strobe_oe;
    logic key_irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } kms_state_t;

  localparam kms_state_t ST_RST = '{
    dir: kms_pkg::DIR_RST,
    lvl: kms_pkg::LVL_RST,
    mask: kms_pkg::MASK_RST,
    ctrl: kms_pkg::CTRL_RST,
    key_seen: 1'b0,
    pos: kms_pkg::SCAN_S0,
    sin_m: 8'hff,
    sin: 8'hff,
    ret_m: 5'h1f,
    ret: 5'h1f,
    strobe_o: 8'hff,
    strobe_oe: 8'h00,
    key_irq: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

  kms_state_t st_q;
  kms_state_t st_d;

  function automatic kms_pkg::kms_scan_t next_pos(kms_pkg::kms_scan_t p);
    kms_pkg::kms_scan_t n;
    n = kms_pkg::SCAN_S0;
    unique case (p)
      kms_pkg::SCAN_S0: n = kms_pkg::SCAN_S1;
      kms_pkg::SCAN_S1: n = kms_pkg::SCAN_S2;
      kms_pkg::SCAN_S2: n = kms_pkg::SCAN_S3;
      kms_pkg::SCAN_S3: n = kms_pkg::SCAN_S4;
      kms_pkg::SCAN_S4: n = kms_pkg::SCAN_S5;
      kms_pkg::SCAN_S5: n = kms_pkg::SCAN_S6;
      kms_pkg::SCAN_S6: n = kms_pkg::SCAN_S7;
      kms_pkg::SCAN_S7: n = kms_pkg::SCAN_S0;
      default: n = kms_pkg::SCAN_S0;
    endcase
    return n;
  endfunction : next_pos

  function automatic logic is_mapped(logic [7:0] a);
    return (a == kms_pkg::ADDR_DIR) || (a == kms_pkg::ADDR_LVL) ||
      (a == kms_pkg::ADDR_RET) || (a == kms_pkg::ADDR_CTRL) ||
      (a == kms_pkg::ADDR_STAT) || (a == kms_pkg::ADDR_SIN) ||
      (a == kms_pkg::ADDR_MASK);
  endfunction : is_mapped

  logic int_tick;
  logic scan_en;
  logic tick_eff;
  logic [4:0] ret_eff;
  logic [7:0] scan_drv;
  logic hit;
  logic key_now;
  logic acc;
  logic wr_done;
  logic [31:0] rd_val;

  kms_frame_timer #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st_q.ctrl[kms_pkg::CTRL_INT_TICK_BIT]),
    .tick(int_tick)
  );

  always_comb
  begin
    st_d = st_q;
    scan_en = st_q.ctrl[kms_pkg::CTRL_SCAN_EN_BIT];
    // Internal divider or the external frame source paces the scan
    tick_eff = scan_en &&
      (st_q.ctrl[kms_pkg::CTRL_INT_TICK_BIT] ? int_tick : frame_tick);
    // Pins from outside pass two flops; no debounce filter on returns
    st_d.sin_m = strobe_i;
    st_d.sin = st_q.sin_m;
    st_d.ret_m = {gpa0_i, ret_i};
    st_d.ret = st_q.ret_m;
    // Unselected fifth return counts as idle high
    ret_eff = {st_q.ret[4] | ~gpa0_alt_sel, st_q.ret[3:0]};
    if (tick_eff)
    begin
      st_d.pos = next_pos(st_q.pos);
    end
    // Masked strobes follow the scan, the rest stay general-purpose
    scan_drv = {8{scan_en}} & st_q.mask;
    st_d.strobe_o = (scan_drv & ~st_q.pos) | (~scan_drv & st_q.lvl);
    st_d.strobe_oe = ~st_q.dir;
    // Returns lag the strobe by the synchroniser depth, so a key on the
    // previous column can flag for two cycles after a step
    hit = scan_en && |(st_q.pos & st_q.mask & st_q.strobe_oe & ~st_q.strobe_o);
    key_now = hit && (ret_eff != 5'h1f);
    st_d.key_irq = key_now;
    // APB: access phase takes two cycles, writes land on the pready edge
    acc = psel && penable;
    wr_done = acc && st_q.pready && pwrite && is_mapped(paddr) && pstrb[0];
    st_d.pready = acc && !st_q.pready;
    st_d.pslverr = acc && !st_q.pready && !is_mapped(paddr);
    rd_val = 32'h0000_0000;
    unique case (paddr)
      kms_pkg::ADDR_DIR: rd_val[7:0] = st_q.dir;
      kms_pkg::ADDR_LVL: rd_val[7:0] = st_q.lvl;
      kms_pkg::ADDR_RET: rd_val[4:0] = {st_q.ret[4] & gpa0_alt_sel, st_q.ret[3:0]};
      kms_pkg::ADDR_CTRL: rd_val[1:0] = st_q.ctrl;
      kms_pkg::ADDR_STAT:
      begin
        rd_val[kms_pkg::STAT_KEY_BIT] = st_q.key_seen;
        rd_val[kms_pkg::STAT_POS_LSB +: 8] = st_q.pos;
      end
      kms_pkg::ADDR_SIN: rd_val[7:0] = st_q.sin;
      kms_pkg::ADDR_MASK: rd_val[7:0] = st_q.mask;
      default: rd_val = 32'h0000_0000;
    endcase
    if (acc && !st_q.pready && !pwrite)
    begin
      st_d.prdata = rd_val;
    end
    if (wr_done)
    begin
      unique case (paddr)
        kms_pkg::ADDR_DIR: st_d.dir = pwdata[7:0];
        kms_pkg::ADDR_LVL: st_d.lvl = pwdata[7:0];
        kms_pkg::ADDR_CTRL: st_d.ctrl = pwdata[1:0];
        kms_pkg::ADDR_MASK: st_d.mask = pwdata[7:0];
        kms_pkg::ADDR_STAT:
        begin
          if (pwdata[kms_pkg::STAT_KEY_BIT])
          begin
            st_d.key_seen = 1'b0;
          end
        end
        default: st_d.dir = st_q.dir;
      endcase
    end
    // A new key event wins over a clear in the same cycle
    if (key_now)
    begin
      st_d.key_seen = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign strobe_o = st_q.strobe_o;
  assign strobe_oe = st_q.strobe_oe;
  assign key_irq = st_q.key_irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_one_low;
    st_q.ctrl[kms_pkg::CTRL_SCAN_EN_BIT] && (st_q.mask == 8'hff) |=>
      ($countones(~strobe_o) == 1);
  endproperty
  a_one_low: assert property (p_one_low) else $error("scan not one low strobe");

  property p_low_is_pos;
    st_q.ctrl[kms_pkg::CTRL_SCAN_EN_BIT] && st_q.mask[3] |=>
      (strobe_o[3] == ~$past(st_q.pos[3]));
  endproperty
  a_low_is_pos: assert property (p_low_is_pos) else $error("strobe 3 not from scan");

  property p_advance;
    tick_eff |=> (st_q.pos == next_pos($past(st_q.pos)));
  endproperty
  a_advance: assert property (p_advance) else $error("scan did not advance");

  property p_hold;
    !tick_eff |=> $stable(st_q.pos);
  endproperty
  a_hold: assert property (p_hold) else $error("scan moved without tick");

  property p_oe_dir;
    1'b1 |=> (strobe_oe == ~$past(st_q.dir));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("strobe enable not from direction");

  property p_level;
    !st_q.ctrl[kms_pkg::CTRL_SCAN_EN_BIT] |=> (strobe_o == $past(st_q.lvl));
  endproperty
  a_level: assert property (p_level) else $error("strobe level not from register");

  property p_irq;
    hit && (st_q.ret[3:0] != 4'hf) |=> key_irq ##0 st_q.key_seen;
  endproperty
  a_irq: assert property (p_irq) else $error("key press not flagged");

  property p_irq_cause;
    key_irq |-> $past(hit);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without low strobe");

  property p_ret5;
    gpa0_alt_sel && hit && !st_q.ret[4] |=> key_irq;
  endproperty
  a_ret5: assert property (p_ret5) else $error("fifth return ignored");

  property p_ret_read;
    acc && !st_q.pready && !pwrite && (paddr == kms_pkg::ADDR_RET) |=>
      pready ##0 (prdata[3:0] == $past(st_q.ret[3:0]));
  endproperty
  a_ret_read: assert property (p_ret_read) else $error("return read wrong");

  property p_dir_write;
    acc && st_q.pready && pwrite && pstrb[0] && (paddr == kms_pkg::ADDR_DIR) |=>
      (st_q.dir == $past(pwdata[7:0])) ##1 (strobe_oe == ~$past(pwdata[7:0], 2));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_ready_once;
    acc && !st_q.pready |=> pready ##1 !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready not single cycle");

endmodule : kms_scanner

`default_nettype wire

// [tb/kms_key_matrix.sv]
// Behavioural key switch matrix seen from the scanner's pins
`timescale 1ns/1ps
`default_nettype none

module kms_key_matrix
(
  // Column levels on the wire
  input wire logic [7:0] col_lvl,
  // Pressed key
  input wire logic press,
  input wire logic [2:0] col,
  input wire logic [2:0] row,
  // Row levels, rows 0..3 dedicated, row 4 shared
  output logic [4:0] row_lvl
);
  // Rows rest high on pull-ups; contacts are clean, so any bounce is software's business
  always_comb
  begin
    row_lvl = 5'h1f;
    if (press && !col_lvl[col])
      row_lvl[row] = 1'b0;
  end
endmodule : kms_key_matrix
`default_nettype wire

// [tb/test_keypad_matrix_scanner.sv]
// Self-checking bench of the keypad matrix scanner
`timescale 1ns/1ps
`default_nettype none

module test_keypad_matrix_scanner;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, frame_tick = 0, alt_sel = 0, press = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] strobe_o, strobe_oe, col_lvl, lvl;
  logic [4:0] row_lvl, exp_ret;
  logic [2:0] col = 3'h0, row = 3'h0;
  logic pready, pslverr, key_irq, er;
  logic [31:0] seed = 32'd98886, d, l;
  int fail_count = 0, check_count = 0, pos, c, r;

  always #10 pclk = ~pclk;
  // Released strobes are pulled up on the board
  assign col_lvl = (strobe_o & strobe_oe) | ~strobe_oe;

  kms_scanner #(.FRAME_CYCLES(16)) u_kms_scanner (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobe_i(col_lvl),
    .strobe_o(strobe_o), .strobe_oe(strobe_oe), .ret_i(row_lvl[3:0]), .gpa0_i(row_lvl[4]),
    .gpa0_alt_sel(alt_sel), .frame_tick(frame_tick), .key_irq(key_irq));

  kms_key_matrix u_kms_key_matrix (.col_lvl(col_lvl), .press(press), .col(col), .row(row),
    .row_lvl(row_lvl));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] exp_strobe(input logic [7:0] lv, input logic [7:0] mask,
                                            input int p);
    return (lv & ~mask) | (mask & ~(8'h01 << p));
  endfunction : exp_strobe

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 50)
      begin
        fail_count++;
        end_of_test();
      end
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial
  begin
    #100us;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(strobe_oe, 32'h0);
    apb(1'b0, kms_pkg::ADDR_DIR, 32'h0);
    chk(rd, 32'hff);
    apb(1'b0, 8'h1c, 32'h0);
    chk(er, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      d = rnd();
      l = rnd();
      apb(1'b1, kms_pkg::ADDR_DIR, d);
      apb(1'b1, kms_pkg::ADDR_LVL, l);
      repeat (3) @(posedge pclk);
      chk({24'h0, ~d[7:0]}, strobe_oe);
      chk({24'h0, l[7:0]}, strobe_o);
    end
    // Static drive of one column, returns read back with and without the shared row
    apb(1'b1, kms_pkg::ADDR_DIR, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      c = rnd() % 8;
      r = rnd() % 5;
      d = rnd();
      col <= c[2:0];
      row <= r[2:0];
      alt_sel <= d[0];
      press <= 1'b1;
      apb(1'b1, kms_pkg::ADDR_LVL, {24'h0, ~(8'h01 << c)});
      repeat (4) @(posedge pclk);
      apb(1'b0, kms_pkg::ADDR_RET, 32'h0);
      exp_ret = 5'h1f & ~(5'h01 << r);
      if (!d[0])
        exp_ret[4] = 1'b0;
      chk(rd, {27'h0, exp_ret});
      chk({31'h0, key_irq}, 32'h0);
    end
    // Scan with the upper four strobes left to software
    c = rnd() % 4;
    r = rnd() % 5;
    l = rnd();
    lvl = l[7:0];
    col <= c[2:0];
    row <= r[2:0];
    alt_sel <= 1'b1;
    apb(1'b1, kms_pkg::ADDR_MASK, 32'h0f);
    apb(1'b1, kms_pkg::ADDR_LVL, l);
    apb(1'b1, kms_pkg::ADDR_CTRL, 32'h1);
    for (int t = 0; t < 10; t++)
    begin
      pos = t % 8;
      repeat (8) @(posedge pclk);
      chk({24'h0, strobe_o}, {24'h0, exp_strobe(lvl, 8'h0f, pos)});
      chk({31'h0, key_irq}, {31'h0, pos == c});
      apb(1'b0, kms_pkg::ADDR_STAT, 32'h0);
      chk({24'h0, rd[15:8]}, {24'h0, 8'h01 << pos});
      frame_tick <= 1'b1;
      @(posedge pclk);
      frame_tick <= 1'b0;
    end
    // Key flag is sticky and cleared by writing one once the key is gone
    chk({31'h0, rd[0]}, 32'h1);
    press <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b1, kms_pkg::ADDR_STAT, 32'h1);
    apb(1'b0, kms_pkg::ADDR_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    // Internal divider paces the scan: captures 16 cycles apart see one step
    apb(1'b1, kms_pkg::ADDR_CTRL, 32'h3);
    repeat (5) @(posedge pclk);
    apb(1'b0, kms_pkg::ADDR_STAT, 32'h0);
    l = rd;
    repeat (12) @(posedge pclk);
    apb(1'b0, kms_pkg::ADDR_STAT, 32'h0);
    chk({24'h0, rd[15:8]}, {24'h0, l[14:8], l[15]});
    // Write without byte strobe 0 is dropped; pins read back through SIN
    apb(1'b1, kms_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, kms_pkg::ADDR_LVL, 32'ha5);
    pstrb <= 4'he;
    apb(1'b1, kms_pkg::ADDR_DIR, 32'h55);
    pstrb <= 4'hf;
    apb(1'b0, kms_pkg::ADDR_DIR, 32'h0);
    chk(rd, 32'h0);
    repeat (4) @(posedge pclk);
    apb(1'b0, kms_pkg::ADDR_SIN, 32'h0);
    chk(rd, 32'ha5);
    // Reset in mid-run returns every strobe to input
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({24'h0, strobe_oe}, 32'h0);
    chk({24'h0, strobe_o}, 32'hff);
    apb(1'b0, kms_pkg::ADDR_DIR, 32'h0);
    chk(rd, 32'hff);
    end_of_test();
  end
endmodule : test_keypad_matrix_scanner
`default_nettype wire
